// ==== tpw_map.svh ====
// Register offsets, field positions, reset values and timing counts of the PWM timer.
// Assumes a 12-bit APB byte address and 32-bit data; included by every design file except the package.
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH

// ============================================================
// Register byte offsets
`define TPW_ADDR_MODE 12'h000
`define TPW_ADDR_CYCLE 12'h004
`define TPW_ADDR_DUTY 12'h008
`define TPW_ADDR_COUNT 12'h00C
`define TPW_ADDR_STATUS 12'h010
`define TPW_ADDR_MASK 12'h014

// ============================================================
// Mode and status register fields
`define TPW_MODE_ENABLE 7
`define TPW_MODE_CKS_HI 6
`define TPW_MODE_CKS_LO 4
`define TPW_MODE_OPM_HI 3
`define TPW_MODE_OPM_LO 2
`define TPW_MODE_OLEV 1
`define TPW_MODE_OEN 0
`define TPW_STATUS_MATCH 0

// ============================================================
// Reset values
`define TPW_MODE_RESET 8'h00
`define TPW_CMP_RESET 8'h00
`define TPW_MASK_RESET 1'b0

// ============================================================
// Timing counts
`define TPW_DUTY_SYNC_TICKS 2'h3
`define TPW_LOW_SPEED_DIV_LOG2 7

`endif

// ==== tpw_pkg.sv ====
// Types and mode decoding of the PWM timer.
// Assumes nothing beyond the register map header.
package tpw_pkg;

    // ============================================================
    // Types
    typedef enum logic {
        TPW_SEL_CYCLE = 1'b0,
        TPW_SEL_DUTY = 1'b1
    } tpw_cmp_sel_type;

    typedef enum logic [1:0] {
        TPW_OPM_INTERVAL = 2'b00,
        TPW_OPM_BAD1 = 2'b01,
        TPW_OPM_PWM = 2'b10,
        TPW_OPM_BAD3 = 2'b11
    } tpw_op_mode_type;

    typedef enum logic [2:0] {
        TPW_CKS_DIV1 = 3'b000,
        TPW_CKS_DIV4 = 3'b001,
        TPW_CKS_DIV16 = 3'b010,
        TPW_CKS_DIV64 = 3'b011,
        TPW_CKS_DIV4096 = 3'b100,
        TPW_CKS_LOW_SPEED = 3'b101,
        TPW_CKS_BAD6 = 3'b110,
        TPW_CKS_BAD7 = 3'b111
    } tpw_cks_type;

    // ============================================================
    // Decoding
    // True for the two operating modes that may run.
    function automatic logic tpw_mode_legal(input logic [1:0] opm);
        return (opm == TPW_OPM_INTERVAL) || (opm == TPW_OPM_PWM);
    endfunction : tpw_mode_legal

    // True for the count clock codes that may run.
    function automatic logic tpw_cks_legal(input logic [2:0] cks);
        return cks <= TPW_CKS_LOW_SPEED;
    endfunction : tpw_cks_legal

endpackage : tpw_pkg

// ==== tpw_prescaler.sv ====
// Count clock prescaler: one-cycle count ticks from the peripheral clock or a low-speed tick.
// Assumes low_speed_tick is a one-cycle pulse synchronous to clk.
`include "tpw_map.svh"

module tpw_prescaler
    import tpw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [2:0] count_clock_select,
    input wire logic low_speed_tick,
    output logic count_tick
);

    logic [11:0] div_count;
    logic [11:0] next_div_count;
    logic [`TPW_LOW_SPEED_DIV_LOG2-1:0] slow_count;
    logic [`TPW_LOW_SPEED_DIV_LOG2-1:0] next_slow_count;
    logic next_count_tick;

    // ============================================================
    // Tap selection
    always_comb begin
        next_div_count = run ? div_count + 12'h001 : 12'h000;
        next_slow_count = slow_count;
        if (!run) begin
            next_slow_count = '0;
        end else if (low_speed_tick) begin
            next_slow_count = slow_count + 1'b1;
        end
        next_count_tick = 1'b0;
        if (run && tpw_cks_legal(count_clock_select)) begin
            unique case (count_clock_select)
                TPW_CKS_DIV1: next_count_tick = 1'b1;
                TPW_CKS_DIV4: next_count_tick = &div_count[1:0];
                TPW_CKS_DIV16: next_count_tick = &div_count[3:0];
                TPW_CKS_DIV64: next_count_tick = &div_count[5:0];
                TPW_CKS_DIV4096: next_count_tick = &div_count;
                TPW_CKS_LOW_SPEED: next_count_tick = low_speed_tick && (&slow_count);
                default: next_count_tick = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_count <= 12'h000;
            slow_count <= '0;
            count_tick <= 1'b0;
        end else begin
            div_count <= next_div_count;
            slow_count <= next_slow_count;
            count_tick <= next_count_tick;
        end
    end

endmodule : tpw_prescaler

// ==== tpw_duty_sync.sv ====
// Duty compare buffer: holds a written duty value and moves it to the active compare value.
// Assumes duty_match is raised only on a count tick in which a duty compare matched.
`include "tpw_map.svh"

module tpw_duty_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic write_strobe,
    input wire logic [7:0] write_data,
    input wire logic running,
    input wire logic count_tick,
    input wire logic duty_match,
    output logic [7:0] duty_latched,
    output logic [7:0] duty_active
);

    logic pending;
    logic [1:0] age;
    logic next_pending;
    logic [1:0] next_age;
    logic [7:0] next_duty_latched;
    logic [7:0] next_duty_active;

    // ============================================================
    // Transfer control
    always_comb begin
        next_pending = pending;
        next_age = age;
        next_duty_latched = duty_latched;
        next_duty_active = duty_active;
        if (write_strobe) begin
            // A write counts ticks from zero whatever the prescaler phase is.
            next_duty_latched = write_data;
            next_age = 2'h0;
            next_pending = running;
            if (!running) begin
                next_duty_active = write_data;
            end
        end else begin
            if (running && count_tick && age != `TPW_DUTY_SYNC_TICKS) begin
                next_age = age + 2'h1;
            end
            // A match too soon after the write keeps the old value for that match.
            if (duty_match && pending && age == `TPW_DUTY_SYNC_TICKS) begin
                next_duty_active = duty_latched;
                next_pending = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending <= 1'b0;
            age <= 2'h0;
            duty_latched <= `TPW_CMP_RESET;
            duty_active <= `TPW_CMP_RESET;
        end else begin
            pending <= next_pending;
            age <= next_age;
            duty_latched <= next_duty_latched;
            duty_active <= next_duty_active;
        end
    end

endmodule : tpw_duty_sync

// ==== tpw_timer.sv ====
// Top of the 8-bit PWM timer: APB registers, counter, compare sequencing, output and interrupt.
// Assumes an APB master on clk and a one-cycle low-speed tick synchronous to clk.
`include "tpw_map.svh"

// Notes on behaviour
// - After counting is enabled the first compare is made against the cycle compare value.
// - A cycle match clears the count, pulses the interrupt; in PWM mode sets the pin active, picks duty, in interval mode toggles the pin.
// - A duty match sets the pin inactive and picks cycle, without clear or interrupt.
// - Cycle value N and duty value M give a period of N+1 and a width of M+1 count clocks.
// - A duty write while counting is latched and made active at the next old-value match.
// - The move needs three or more count clocks after the write, else the old value is kept.
// - A duty write is accepted at any moment and aligned to the count clock internally.
// - Enabling the count masks the first count clock and the pin stays at its inactive level.
// - Clearing the enable bit forces the match interrupt and the output inactive.
// - Clearing the enable bit stops counting and resets the counter to zero.
module tpw_timer
    import tpw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic low_speed_tick,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic timer_output_pin,
    output logic match_interrupt,
    output logic irq
);

    logic [7:0] timer_mode_reg;
    logic [7:0] cycle_compare;
    logic [7:0] counter;
    logic match_status;
    logic match_mask;
    logic first_masked;
    logic pwm_active;
    tpw_cmp_sel_type cmp_sel;

    logic [7:0] next_timer_mode_reg;
    logic [7:0] next_cycle_compare;
    logic [7:0] next_counter;
    logic next_match_status;
    logic next_match_mask;
    logic next_first_masked;
    logic next_pwm_active;
    tpw_cmp_sel_type next_cmp_sel;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_timer_output_pin;
    logic next_match_interrupt;
    logic next_irq;

    logic count_enable_bit;
    logic output_level_bit;
    logic output_enable_bit;
    logic [1:0] op_mode;
    logic [2:0] count_clock_select;
    logic running;
    logic count_tick;
    logic cycle_match;
    logic duty_match;
    logic bus_write;
    logic bus_setup;
    logic duty_write;
    logic [7:0] duty_latched;
    logic [7:0] duty_active;

    // ============================================================
    // Field decode
    assign count_enable_bit = timer_mode_reg[`TPW_MODE_ENABLE];
    assign count_clock_select = timer_mode_reg[`TPW_MODE_CKS_HI:`TPW_MODE_CKS_LO];
    assign op_mode = timer_mode_reg[`TPW_MODE_OPM_HI:`TPW_MODE_OPM_LO];
    assign output_level_bit = timer_mode_reg[`TPW_MODE_OLEV];
    assign output_enable_bit = timer_mode_reg[`TPW_MODE_OEN];
    assign running = count_enable_bit && tpw_mode_legal(op_mode);
    assign bus_setup = psel && !penable;
    assign bus_write = psel && penable && pwrite;
    assign duty_write = bus_write && (paddr == `TPW_ADDR_DUTY);

    // ============================================================
    // Submodules
    tpw_prescaler u_prescaler (
        .clk(clk),
        .rst_b(rst_b),
        .run(running),
        .count_clock_select(count_clock_select),
        .low_speed_tick(low_speed_tick),
        .count_tick(count_tick)
    );

    tpw_duty_sync u_duty_sync (
        .clk(clk),
        .rst_b(rst_b),
        .write_strobe(duty_write),
        .write_data(pwdata[7:0]),
        .running(running),
        .count_tick(count_tick),
        .duty_match(duty_match),
        .duty_latched(duty_latched),
        .duty_active(duty_active)
    );

    // ============================================================
    // Compare sequencing
    // The interval mode never looks at the duty compare value.
    assign cycle_match = running && count_tick && !first_masked
        && (cmp_sel == TPW_SEL_CYCLE) && (counter == cycle_compare);
    assign duty_match = running && count_tick && !first_masked
        && (op_mode == TPW_OPM_PWM) && (cmp_sel == TPW_SEL_DUTY)
        && (counter == duty_active);

    always_comb begin
        next_counter = counter;
        next_first_masked = first_masked;
        next_pwm_active = pwm_active;
        next_cmp_sel = cmp_sel;
        next_match_interrupt = 1'b0;
        if (!running) begin
            next_counter = 8'h00;
            next_first_masked = 1'b1;
            next_pwm_active = 1'b0;
            next_cmp_sel = TPW_SEL_CYCLE;
        end else if (count_tick) begin
            if (first_masked) begin
                next_first_masked = 1'b0;
            end else if (cycle_match) begin
                next_counter = 8'h00;
                next_match_interrupt = 1'b1;
                if (op_mode == TPW_OPM_PWM) begin
                    next_pwm_active = 1'b1;
                    next_cmp_sel = TPW_SEL_DUTY;
                end else begin
                    next_pwm_active = !pwm_active;
                end
            end else if (duty_match) begin
                next_pwm_active = 1'b0;
                next_cmp_sel = TPW_SEL_CYCLE;
                next_counter = counter + 8'h01;
            end else begin
                next_counter = counter + 8'h01;
            end
        end
        // The pin rests at the level bit whenever the pulse is inactive or the output is off.
        next_timer_output_pin = output_level_bit
            ^ (output_enable_bit && next_pwm_active);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            counter <= 8'h00;
            first_masked <= 1'b1;
            pwm_active <= 1'b0;
            cmp_sel <= TPW_SEL_CYCLE;
            match_interrupt <= 1'b0;
            timer_output_pin <= 1'b0;
        end else begin
            counter <= next_counter;
            first_masked <= next_first_masked;
            pwm_active <= next_pwm_active;
            cmp_sel <= next_cmp_sel;
            match_interrupt <= next_match_interrupt;
            timer_output_pin <= next_timer_output_pin;
        end
    end

    // ============================================================
    // Register file and interrupt
    always_comb begin
        next_timer_mode_reg = timer_mode_reg;
        next_cycle_compare = cycle_compare;
        next_match_mask = match_mask;
        next_match_status = match_status;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (bus_write) begin
            unique case (paddr)
                `TPW_ADDR_MODE: next_timer_mode_reg = pwdata[7:0];
                `TPW_ADDR_CYCLE: next_cycle_compare = pwdata[7:0];
                `TPW_ADDR_MASK: next_match_mask = pwdata[`TPW_STATUS_MATCH];
                `TPW_ADDR_STATUS: begin
                    if (pwdata[`TPW_STATUS_MATCH]) begin
                        next_match_status = 1'b0;
                    end
                end
                default: next_match_status = match_status;
            endcase
        end
        // A match in the clearing cycle keeps the status bit set.
        if (cycle_match) begin
            next_match_status = 1'b1;
        end
        if (bus_setup) begin
            next_pslverr = 1'b0;
            unique case (paddr)
                `TPW_ADDR_MODE: next_prdata = {24'h00_0000, timer_mode_reg};
                `TPW_ADDR_CYCLE: next_prdata = {24'h00_0000, cycle_compare};
                `TPW_ADDR_DUTY: next_prdata = {24'h00_0000, duty_latched};
                `TPW_ADDR_COUNT: next_prdata = {24'h00_0000, counter};
                `TPW_ADDR_STATUS: next_prdata = {31'h0000_0000, match_status};
                `TPW_ADDR_MASK: next_prdata = {31'h0000_0000, match_mask};
                default: begin
                    next_prdata = 32'h0000_0000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        next_irq = next_match_status && next_match_mask;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_mode_reg <= `TPW_MODE_RESET;
            cycle_compare <= `TPW_CMP_RESET;
            match_mask <= `TPW_MASK_RESET;
            match_status <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
            irq <= 1'b0;
        end else begin
            timer_mode_reg <= next_timer_mode_reg;
            cycle_compare <= next_cycle_compare;
            match_mask <= next_match_mask;
            match_status <= next_match_status;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            pready <= 1'b1;
            irq <= next_irq;
        end
    end

endmodule : tpw_timer

// ==== tpw_timer_monitor.sv ====
// Checker of the PWM timer, bound to its top module.
// Assumes APB writes take effect when psel, penable and pready are high.
`include "tpw_map.svh"
module tpw_timer_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic low_speed_tick,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_output_pin,
    input wire logic match_interrupt,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // Shadow of the written registers and the gap between matches.
    logic wr;
    logic [7:0] mode_q, next_mode_q, cycle_q, next_cycle_q;
    logic mask_q, next_mask_q, gap_ok, next_gap_ok;
    logic [8:0] gap_q, next_gap_q;
    assign wr = psel && penable && pwrite && pready;
    always_comb begin
        next_mode_q = (wr && paddr == `TPW_ADDR_MODE) ? pwdata[7:0] : mode_q;
        next_cycle_q = (wr && paddr == `TPW_ADDR_CYCLE) ? pwdata[7:0] : cycle_q;
        next_mask_q = (wr && paddr == `TPW_ADDR_MASK) ? pwdata[0] : mask_q;
        next_gap_q = match_interrupt ? 9'h001 : gap_q + 9'h001;
        next_gap_ok = !(wr && paddr < `TPW_ADDR_DUTY) && (match_interrupt || gap_ok);
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 8'h00;
            cycle_q <= 8'h00;
            mask_q <= 1'b0;
            gap_q <= 9'h000;
            gap_ok <= 1'b0;
        end else begin
            mode_q <= next_mode_q;
            cycle_q <= next_cycle_q;
            mask_q <= next_mask_q;
            gap_q <= next_gap_q;
            gap_ok <= next_gap_ok;
        end
    end
    // ====================
    // Properties.
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_mode_wr;
        wr && paddr == `TPW_ADDR_MODE;
    endsequence
    sequence s_start;
        s_mode_wr ##0 pwdata[`TPW_MODE_ENABLE];
    endsequence
    sequence s_stop;
        s_mode_wr ##0 !pwdata[`TPW_MODE_ENABLE];
    endsequence
    property p_pulse; match_interrupt |=> !match_interrupt; endproperty
    a_pulse: assert property (p_pulse) else $error("match pulse too long");
    property p_active; match_interrupt && mode_q[3:2] == 2'h2 |->
        timer_output_pin == (mode_q[1] ^ mode_q[0]); endproperty
    a_active: assert property (p_active) else $error("pin not active at match");
    property p_period; match_interrupt && gap_ok && mode_q[7:2] == 6'h22 |->
        gap_q == {1'b0, cycle_q} + 9'h001; endproperty
    a_period: assert property (p_period) else $error("wrong period");
    property p_start; s_start |-> ##2 timer_output_pin == mode_q[1]; endproperty
    a_start: assert property (p_start) else $error("pin active at start");
    property p_stop; s_stop |-> ##3 (!match_interrupt && timer_output_pin == mode_q[1]) [*4];
    endproperty
    a_stop: assert property (p_stop) else $error("outputs not idle after stop");
    property p_fall; $changed(timer_output_pin) && timer_output_pin == mode_q[1] && mode_q[7]
        && mode_q[3] |-> !match_interrupt; endproperty
    a_fall: assert property (p_fall) else $error("interrupt at duty match");
    property p_irq_rise; $rose(irq) |-> mask_q; endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq while masked");
    property p_irq_low; !mask_q && !$past(mask_q) |-> !irq; endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq with mask clear");
    property p_slverr; psel && !penable && (paddr > `TPW_ADDR_MASK || paddr[1:0] != 2'h0)
        |=> pslverr; endproperty
    a_slverr: assert property (p_slverr) else $error("no error on unmapped access");
endmodule : tpw_timer_monitor

// ==== tpw_load_model.sv ====
// External load on the PWM pin: measures period and active width in clock cycles.
// Assumes active_level gives the pin level that the load treats as active.
module tpw_load_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic active_level,
    input wire logic pin,
    output logic [15:0] high_width,
    output logic [15:0] period,
    output logic [7:0] edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_q, rise, fall;
    logic [15:0] run, wid, next_run, next_wid, next_high_width, next_period;
    logic [7:0] next_edges;
    assign rise = pin == active_level && pin_q != active_level;
    assign fall = pin != active_level && pin_q == active_level;
    always_comb begin
        next_run = rise ? 16'h0001 : run + 16'h0001;
        next_wid = rise ? 16'h0001 : wid + 16'h0001;
        next_period = rise ? run : period;
        next_high_width = fall ? wid : high_width;
        next_edges = rise ? edges + 8'h01 : edges;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q <= 1'b0;
            {run, wid, period, high_width, edges} <= '0;
        end else begin
            pin_q <= pin;
            {run, wid, period, high_width, edges} <=
                {next_run, next_wid, next_period, next_high_width, next_edges};
        end
    end
endmodule : tpw_load_model

// ==== timer_pwm_output_bench.sv ====
// Self-checking bench of the PWM timer: registers, PWM rows, duty buffering, stop, interrupt.
// Assumes the design, the monitor and the load model are compiled first.
`include "tpw_map.svh"
module timer_pwm_output_bench
    import tpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {tpw_cks_type cks; logic olev; logic [7:0] n; logic [7:0] m; int div;}
        tpw_row_type;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic low_speed_tick = 1'b0, act_lvl = 1'b1, pready, pslverr, pin, match_interrupt, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [15:0] high_width, period;
    logic [7:0] edges;
    logic [7:0] bad[2] = '{8'hE9, 8'h85};
    int errors = 0, compares = 0;
    tpw_row_type rows[9] = '{'{TPW_CKS_DIV1, 1'b0, 8'h04, 8'h01, 1},
        '{TPW_CKS_DIV1, 1'b1, 8'h01, 8'h00, 1}, '{TPW_CKS_DIV1, 1'b0, 8'hFF, 8'hFE, 1},
        '{TPW_CKS_DIV1, 1'b1, 8'hFF, 8'h00, 1}, '{TPW_CKS_DIV4, 1'b0, 8'h03, 8'h02, 4},
        '{TPW_CKS_DIV16, 1'b1, 8'h02, 8'h00, 16}, '{TPW_CKS_DIV64, 1'b0, 8'h01, 8'h00, 64},
        '{TPW_CKS_DIV4096, 1'b0, 8'h01, 8'h00, 4096},
        '{TPW_CKS_LOW_SPEED, 1'b1, 8'h01, 8'h00, 256}};
    tpw_timer dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .low_speed_tick(low_speed_tick), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_output_pin(pin),
        .match_interrupt(match_interrupt), .irq(irq));
    tpw_load_model u_load (.clk(clk), .rst_b(rst_b), .active_level(act_lvl), .pin(pin),
        .high_width(high_width), .period(period), .edges(edges));
    initial begin
        forever #5 clk = ~clk;
    end
    // The low-speed tick pulses every second cycle, so that source divides by 256.
    always @(posedge clk) low_speed_tick <= !low_speed_tick;
    // ====================
    // Tasks.
    task automatic summarize();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        if (pready !== 1'b1) begin
            errors++;
            summarize();
        end
        {psel, penable} <= 2'h0;
        @(posedge clk);
    endtask : apb
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, rd);
    endtask : rd_chk
    task automatic wait_for(input int n, input logic lvl);
        int k;
        int target;
        target = edges + n;
        k = 0;
        while ((n > 0 ? edges != target[7:0] : pin !== lvl) && k < 40000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 40000) begin
            errors++;
            summarize();
        end
    endtask : wait_for
    // ====================
    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 6; a++) rd_chk("reset value", 12'(a * 4), 32'h0000_0000);
        apb(1'b1, `TPW_ADDR_COUNT, 32'h0000_0055);
        rd_chk("counter read only", `TPW_ADDR_COUNT, 32'h0000_0000);
        rd_chk("unmapped", 12'h018, 32'h0000_0000);
        check("slverr", 32'h0000_0001, {31'h0000_0000, pslverr});
        apb(1'b1, `TPW_ADDR_MASK, 32'h0000_0001);
        rd_chk("mask", `TPW_ADDR_MASK, 32'h0000_0001);
        foreach (rows[i]) begin
            apb(1'b1, `TPW_ADDR_DUTY, {24'h00_0000, rows[i].m});
            apb(1'b1, `TPW_ADDR_CYCLE, {24'h00_0000, rows[i].n});
            act_lvl <= !rows[i].olev;
            apb(1'b1, `TPW_ADDR_MODE, {24'h00_0000, 1'b1, rows[i].cks, 2'h2, rows[i].olev, 1'b1});
            wait_for(3, 1'b0);
            check("period", (rows[i].n + 32'h0000_0001) * rows[i].div, period);
            check("width", (rows[i].m + 32'h0000_0001) * rows[i].div, high_width);
            apb(1'b1, `TPW_ADDR_MODE, {24'h00_0000, 1'b0, rows[i].cks, 2'h2, rows[i].olev, 1'b1});
            rd_chk("stopped count", `TPW_ADDR_COUNT, 32'h0000_0000);
        end
        // A duty write inside a short pulse is too young for the match that ends it.
        apb(1'b1, `TPW_ADDR_DUTY, 32'h0000_0002);
        apb(1'b1, `TPW_ADDR_CYCLE, 32'h0000_000A);
        act_lvl <= 1'b1;
        apb(1'b1, `TPW_ADDR_MODE, 32'h0000_0099);
        wait_for(1, 1'b0);
        apb(1'b1, `TPW_ADDR_DUTY, 32'h0000_0005);
        wait_for(1, 1'b0);
        check("young write", 32'h0000_000C, high_width);
        wait_for(1, 1'b0);
        check("transfer match", 32'h0000_000C, high_width);
        wait_for(1, 1'b0);
        check("new duty", 32'h0000_0018, high_width);
        wait_for(0, 1'b0);
        apb(1'b1, `TPW_ADDR_DUTY, 32'h0000_0002);
        wait_for(2, 1'b0);
        check("old duty kept", 32'h0000_0018, high_width);
        wait_for(1, 1'b0);
        check("aged write", 32'h0000_000C, high_width);
        wait_for(0, 1'b1);
        apb(1'b1, `TPW_ADDR_MODE, 32'h0000_0019);
        rd_chk("count after stop", `TPW_ADDR_COUNT, 32'h0000_0000);
        check("pin after stop", 32'h0000_0000, {31'h0000_0000, pin});
        // Interrupt: clear, masked event, unmask, clear again.
        apb(1'b1, `TPW_ADDR_STATUS, 32'h0000_0001);
        rd_chk("status cleared", `TPW_ADDR_STATUS, 32'h0000_0000);
        check("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
        apb(1'b1, `TPW_ADDR_MASK, 32'h0000_0000);
        apb(1'b1, `TPW_ADDR_DUTY, 32'h0000_0001);
        apb(1'b1, `TPW_ADDR_CYCLE, 32'h0000_0003);
        apb(1'b1, `TPW_ADDR_MODE, 32'h0000_0089);
        wait_for(2, 1'b0);
        check("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
        rd_chk("status set", `TPW_ADDR_STATUS, 32'h0000_0001);
        apb(1'b1, `TPW_ADDR_MASK, 32'h0000_0001);
        @(posedge clk);
        check("irq unmasked", 32'h0000_0001, {31'h0000_0000, irq});
        apb(1'b1, `TPW_ADDR_MODE, 32'h0000_0009);
        apb(1'b1, `TPW_ADDR_STATUS, 32'h0000_0001);
        rd_chk("status after clear", `TPW_ADDR_STATUS, 32'h0000_0000);
        check("irq after clear", 32'h0000_0000, {31'h0000_0000, irq});
        // Reserved clock code and reserved mode must not count.
        foreach (bad[i]) begin
            apb(1'b1, `TPW_ADDR_MODE, {24'h00_0000, bad[i]});
            rd_chk("no count", `TPW_ADDR_COUNT, 32'h0000_0000);
            rd_chk("still no count", `TPW_ADDR_COUNT, 32'h0000_0000);
            apb(1'b1, `TPW_ADDR_MODE, {24'h00_0000, bad[i] & 8'h7F});
        end
        apb(1'b1, `TPW_ADDR_MODE, 32'h0000_0081);
        wait_for(2, 1'b0);
        check("interval period", 32'h0000_0008, period);
        summarize();
    end
endmodule : timer_pwm_output_bench

bind tpw_timer tpw_timer_monitor u_mon (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .low_speed_tick(low_speed_tick), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_output_pin(timer_output_pin), .match_interrupt(match_interrupt), .irq(irq));
